// file: src/tlma_pkg.sv
package tlma_pkg;
  // physical-layer modes
  localparam logic [1:0] TLMA_MODE_USB3 = 2'h0;
  localparam logic [1:0] TLMA_MODE_DP   = 2'h1;
  localparam logic [1:0] TLMA_MODE_CONC = 2'h2;

  // lane indices
  localparam int TLMA_LANE_N  = 4;
  localparam int TLMA_LANE_00 = 0;
  localparam int TLMA_LANE_01 = 1;
  localparam int TLMA_LANE_10 = 2;
  localparam int TLMA_LANE_11 = 3;

  // lane source codes; dp main links carry their index in the low bits
  localparam logic [2:0] TLMA_SRC_NONE   = 3'h0;
  localparam logic [2:0] TLMA_SRC_USB_TX = 3'h1;
  localparam logic [2:0] TLMA_SRC_USB_RX = 3'h2;
  localparam logic [2:0] TLMA_SRC_ML0    = 3'h4;
  localparam logic [2:0] TLMA_SRC_ML1    = 3'h5;
  localparam logic [2:0] TLMA_SRC_ML2    = 3'h6;
  localparam logic [2:0] TLMA_SRC_ML3    = 3'h7;
  localparam int         TLMA_SRC_DP_BIT = 2;

  // sampled pin vector positions
  localparam int TLMA_PIN_N     = 6;
  localparam int TLMA_PIN_VBUS  = 0;
  localparam int TLMA_PIN_DP    = 1;
  localparam int TLMA_PIN_DM    = 2;
  localparam int TLMA_PIN_CC1   = 3;
  localparam int TLMA_PIN_CC2   = 4;
  localparam int TLMA_PIN_PSEL  = 5;

  // timing
  localparam int TLMA_CLK_PERIOD_PS   = 4000;
  localparam int TLMA_VBUS_SETTLE_NS  = 1000;
  localparam int TLMA_VBUS_SETTLE_CYC =
    (TLMA_VBUS_SETTLE_NS * 1000 + TLMA_CLK_PERIOD_PS - 1) / TLMA_CLK_PERIOD_PS;
  localparam int TLMA_CNT_W = 12;

  localparam int TLMA_FIFO_DEPTH = 32;
  localparam int TLMA_LANE_W     = 10;

  typedef enum logic [4:0] {
    TLMA_ST_DETACHED = 5'h01,
    TLMA_ST_VBUS     = 5'h02,
    TLMA_ST_LINES    = 5'h04,
    TLMA_ST_DATA     = 5'h08,
    TLMA_ST_CHARGER  = 5'h10
  } tlma_att_t;
endpackage

// file: src/tlma_top.sv
`timescale 1ns/10ps

module tlma_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Operation
// - usb3 mode, select 0: tx on lane_0_0, rx on lane_0_1, lane_1 idle
// - usb3 mode, select 1: tx on lane_1_0, rx on lane_1_1 only
// - dp mode: all four lanes transmit dp main links, no usb traffic
// - dp mode lane order: sel 0 ml2,ml3,ml1,ml0; sel 1 ml1,ml0,ml2,ml3
// - concurrent: sel 0 usb on lane_0, dp ml1/ml0 on lane_1; sel 1 swaps
// - cc orientation shown on its own tri-state 1.8 v output
// - on attach sense vbus first, then d+/d- to tell data cable from charger
// - the secondary high-speed port works only as a host
module tlma_top
#(
  parameter int LW         = tlma_pkg::TLMA_LANE_W,
  parameter int FIFO_DEPTH = tlma_pkg::TLMA_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // mode control
  input  wire logic [1:0]             phy_mode,
  input  wire logic                   link_en,
  // attach pins
  input  wire logic                   vbus_sense,
  input  wire logic                   dp_line,
  input  wire logic                   dm_line,
  input  wire logic                   cc1_sense,
  input  wire logic                   cc2_sense,
  input  wire logic                   phy_port_select,
  // orientation pin
  output logic                        cc_orientation_out_o,
  output logic                        cc_orientation_out_oe,
  // attach status
  output logic                        attach_data,
  output logic                        attach_charger,
  output logic                        port_select,
  // secondary high-speed port role
  output logic                        secondary_hs_host,
  output logic                        secondary_hs_pos_pd_en,
  output logic                        secondary_hs_neg_pd_en,
  // usb transmit stream
  input  wire logic                   usb_tx_valid,
  output logic                        usb_tx_ready,
  input  wire logic [LW-1:0]          usb_tx_data,
  // usb receive stream
  output logic                        usb_rx_valid,
  output logic [LW-1:0]               usb_rx_data,
  // dp main links
  input  wire logic [3:0][LW-1:0]     dp_ml_data,
  // lane pairs
  output logic [3:0][LW-1:0]          lane_tx_data,
  output logic [3:0]                  lane_tx_en,
  input  wire logic [3:0][LW-1:0]     lane_rx_data
);
  import tlma_pkg::*;

  logic                  rst_meta_q;
  logic                  rst_n;
  logic [TLMA_PIN_N-1:0] pin_s1_q;
  logic [TLMA_PIN_N-1:0] pin_s2_q;
  logic [TLMA_PIN_N-1:0] pin_s3_q;
  logic [TLMA_PIN_N-1:0] pin_q;
  tlma_att_t             att_q;
  logic [TLMA_CNT_W-1:0] cnt_q;
  logic                  psel_q;
  logic                  orient_q;
  logic                  orient_oe_q;
  logic [3:0][2:0]       route;
  logic                  tx_lane_on;
  logic                  rx_lane_on;
  logic [1:0]            rx_idx;
  logic                  fifo_valid;
  logic [LW-1:0]         fifo_data;
  logic                  fifo_pop;

  // reset release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // pin sampling, a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q    <= '0;
    end else begin
      pin_s1_q <= {phy_port_select, cc2_sense, cc1_sense,
                   dm_line, dp_line, vbus_sense};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < TLMA_PIN_N; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // attach classification
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      att_q <= TLMA_ST_DETACHED;
      cnt_q <= '0;
    end else begin
      unique case (att_q)
        TLMA_ST_DETACHED: begin
          cnt_q <= '0;
          if (pin_q[TLMA_PIN_VBUS]) att_q <= TLMA_ST_VBUS;
        end
        TLMA_ST_VBUS: begin
          if (!pin_q[TLMA_PIN_VBUS]) begin
            att_q <= TLMA_ST_DETACHED;
          end else if (cnt_q == TLMA_CNT_W'(TLMA_VBUS_SETTLE_CYC - 1)) begin
            att_q <= TLMA_ST_LINES;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        TLMA_ST_LINES: begin
          if (!pin_q[TLMA_PIN_VBUS]) begin
            att_q <= TLMA_ST_DETACHED;
          end else if (!pin_q[TLMA_PIN_DP] && !pin_q[TLMA_PIN_DM]) begin
            att_q <= TLMA_ST_DATA;
          end else begin
            att_q <= TLMA_ST_CHARGER;
          end
        end
        TLMA_ST_DATA, TLMA_ST_CHARGER: begin
          if (!pin_q[TLMA_PIN_VBUS]) att_q <= TLMA_ST_DETACHED;
        end
        default: att_q <= TLMA_ST_DETACHED;
      endcase
    end
  end

  assign attach_data    = (att_q == TLMA_ST_DATA);
  assign attach_charger = (att_q == TLMA_ST_CHARGER);

  // orientation report on the tri-state pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      orient_q    <= 1'b0;
      orient_oe_q <= 1'b0;
    end else begin
      orient_q    <= pin_q[TLMA_PIN_CC2] & ~pin_q[TLMA_PIN_CC1];
      orient_oe_q <= pin_q[TLMA_PIN_CC1] ^ pin_q[TLMA_PIN_CC2];
    end
  end
  assign cc_orientation_out_o  = orient_q;
  assign cc_orientation_out_oe = orient_oe_q;

  // lane select tracks the pin only while the link is down
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      psel_q <= 1'b0;
    end else if (!link_en) begin
      psel_q <= pin_q[TLMA_PIN_PSEL];
    end
  end
  assign port_select = psel_q;

  // secondary port: host pull-downs only, no device pull-up path
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      secondary_hs_host      <= 1'b0;
      secondary_hs_pos_pd_en <= 1'b0;
      secondary_hs_neg_pd_en <= 1'b0;
    end else begin
      secondary_hs_host      <= 1'b1;
      secondary_hs_pos_pd_en <= 1'b1;
      secondary_hs_neg_pd_en <= 1'b1;
    end
  end

  // lane routing table
  always_comb begin
    route = {4{TLMA_SRC_NONE}};
    unique case ({phy_mode, psel_q})
      {TLMA_MODE_USB3, 1'b0}: begin
        route[TLMA_LANE_00] = TLMA_SRC_USB_TX;
        route[TLMA_LANE_01] = TLMA_SRC_USB_RX;
      end
      {TLMA_MODE_USB3, 1'b1}: begin
        route[TLMA_LANE_10] = TLMA_SRC_USB_TX;
        route[TLMA_LANE_11] = TLMA_SRC_USB_RX;
      end
      {TLMA_MODE_DP, 1'b0}: begin
        route[TLMA_LANE_00] = TLMA_SRC_ML2;
        route[TLMA_LANE_01] = TLMA_SRC_ML3;
        route[TLMA_LANE_10] = TLMA_SRC_ML1;
        route[TLMA_LANE_11] = TLMA_SRC_ML0;
      end
      {TLMA_MODE_DP, 1'b1}: begin
        route[TLMA_LANE_00] = TLMA_SRC_ML1;
        route[TLMA_LANE_01] = TLMA_SRC_ML0;
        route[TLMA_LANE_10] = TLMA_SRC_ML2;
        route[TLMA_LANE_11] = TLMA_SRC_ML3;
      end
      {TLMA_MODE_CONC, 1'b0}: begin
        route[TLMA_LANE_00] = TLMA_SRC_USB_TX;
        route[TLMA_LANE_01] = TLMA_SRC_USB_RX;
        route[TLMA_LANE_10] = TLMA_SRC_ML1;
        route[TLMA_LANE_11] = TLMA_SRC_ML0;
      end
      {TLMA_MODE_CONC, 1'b1}: begin
        route[TLMA_LANE_00] = TLMA_SRC_ML1;
        route[TLMA_LANE_01] = TLMA_SRC_ML0;
        route[TLMA_LANE_10] = TLMA_SRC_USB_TX;
        route[TLMA_LANE_11] = TLMA_SRC_USB_RX;
      end
      default: route = {4{TLMA_SRC_NONE}};
    endcase
  end

  always_comb begin
    tx_lane_on = 1'b0;
    rx_lane_on = 1'b0;
    rx_idx     = 2'h0;
    for (int i = 0; i < TLMA_LANE_N; i++) begin
      if (route[i] == TLMA_SRC_USB_TX) begin
        tx_lane_on = link_en;
      end
      if (route[i] == TLMA_SRC_USB_RX) begin
        rx_lane_on = link_en;
        rx_idx     = 2'(i);
      end
    end
  end

  // usb transmit buffer, stalls when no lane carries usb
  assign fifo_pop = fifo_valid & tx_lane_on;

  tlma_fifo #(
    .W     (LW),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (usb_tx_valid),
    .in_ready  (usb_tx_ready),
    .in_data   (usb_tx_data),
    .out_valid (fifo_valid),
    .out_ready (tx_lane_on),
    .out_data  (fifo_data)
  );

  // per-lane transmit registers
  for (genvar g = 0; g < TLMA_LANE_N; g++) begin : g_lane
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        lane_tx_data[g] <= '0;
        lane_tx_en[g]   <= 1'b0;
      end else if (!link_en) begin
        lane_tx_data[g] <= '0;
        lane_tx_en[g]   <= 1'b0;
      end else if (route[g][TLMA_SRC_DP_BIT]) begin
        lane_tx_data[g] <= dp_ml_data[route[g][1:0]];
        lane_tx_en[g]   <= 1'b1;
      end else if (route[g] == TLMA_SRC_USB_TX) begin
        lane_tx_data[g] <= fifo_pop ? fifo_data : '0;
        lane_tx_en[g]   <= 1'b1;
      end else begin
        lane_tx_data[g] <= '0;
        lane_tx_en[g]   <= 1'b0;
      end
    end
  end

  // usb receive capture from the assigned lane
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      usb_rx_valid <= 1'b0;
      usb_rx_data  <= '0;
    end else begin
      usb_rx_valid <= rx_lane_on;
      usb_rx_data  <= rx_lane_on ? lane_rx_data[rx_idx] : '0;
    end
  end
endmodule

// file: testbench/tlma_checker.sv
`timescale 1ns/10ps
module tlma_checker
  import tlma_pkg::*;
#(
  parameter int LW = 10
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               nrst,
  // controls and pins
  input wire logic [1:0]         phy_mode,
  input wire logic               link_en,
  input wire logic               vbus_sense,
  input wire logic               cc1_sense,
  input wire logic               cc2_sense,
  // status
  input wire logic               cc_orientation_out_o,
  input wire logic               cc_orientation_out_oe,
  input wire logic               attach_data,
  input wire logic               attach_charger,
  input wire logic               port_select,
  input wire logic               secondary_hs_host,
  // lanes
  input wire logic               usb_rx_valid,
  input wire logic [LW-1:0]      usb_rx_data,
  input wire logic [3:0][LW-1:0] dp_ml_data,
  input wire logic [3:0][LW-1:0] lane_tx_data,
  input wire logic [3:0]         lane_tx_en,
  input wire logic [3:0][LW-1:0] lane_rx_data
);
  int                 rcnt;
  int                 vcnt;
  logic [3:0][LW-1:0] ml_q;
  logic [3:0][LW-1:0] rx_q;
  logic               ok;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rcnt <= 0;
      vcnt <= 0;
    end else begin
      rcnt <= (rcnt < 15) ? rcnt + 1 : rcnt;
      vcnt <= vbus_sense ? vcnt + 1 : 0;
    end
  end
  always_ff @(posedge clk_sys) begin
    ml_q <= dp_ml_data;
    rx_q <= lane_rx_data;
  end
  assign ok = rcnt > 6;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_lane_map(m, s, en);
    ok && phy_mode == m && link_en && port_select == s |=> lane_tx_en == en;
  endproperty
  property p_usb3_s0; p_lane_map(TLMA_MODE_USB3, 1'b0, 4'h1); endproperty
  a_usb3_s0: assert property (p_usb3_s0) else $error("usb3 sel0 lanes");
  property p_usb3_s1; p_lane_map(TLMA_MODE_USB3, 1'b1, 4'h4); endproperty
  a_usb3_s1: assert property (p_usb3_s1) else $error("usb3 sel1 lanes");
  property p_dp_en; p_lane_map(TLMA_MODE_DP, 1'b0, 4'hf); endproperty
  a_dp_en: assert property (p_dp_en) else $error("dp lanes off");
  property p_conc_en; p_lane_map(TLMA_MODE_CONC, 1'b1, 4'h7); endproperty
  a_conc_en: assert property (p_conc_en) else $error("conc lanes");

  property p_dp_order;
    ok && phy_mode == TLMA_MODE_DP && link_en |=> $past(port_select)
      ? lane_tx_data == {ml_q[3], ml_q[2], ml_q[0], ml_q[1]}
      : lane_tx_data == {ml_q[0], ml_q[1], ml_q[3], ml_q[2]};
  endproperty
  a_dp_order: assert property (p_dp_order) else $error("dp order");
  property p_conc_dp;
    ok && phy_mode == TLMA_MODE_CONC && link_en |=> $past(port_select)
      ? lane_tx_data[1:0] == {ml_q[0], ml_q[1]}
      : lane_tx_data[3:2] == {ml_q[0], ml_q[1]};
  endproperty
  a_conc_dp: assert property (p_conc_dp) else $error("conc dp lanes");
  property p_rx;
    ok && phy_mode == TLMA_MODE_USB3 && link_en && !port_select
      |=> usb_rx_valid && usb_rx_data == rx_q[1];
  endproperty
  a_rx: assert property (p_rx) else $error("usb rx lane");

  sequence s_cc_steady;
    (ok && $stable(cc1_sense) && $stable(cc2_sense)) [*6];
  endsequence
  property p_orient;
    s_cc_steady |-> cc_orientation_out_oe == (cc1_sense ^ cc2_sense) &&
      (!cc_orientation_out_oe || cc_orientation_out_o == cc2_sense);
  endproperty
  a_orient: assert property (p_orient) else $error("orientation");
  property p_attach;
    $rose(attach_data || attach_charger) |-> vcnt >= TLMA_VBUS_SETTLE_CYC;
  endproperty
  a_attach: assert property (p_attach) else $error("early attach");
  property p_host; ok |-> secondary_hs_host; endproperty
  a_host: assert property (p_host) else $error("secondary not host");
  property p_hold; ok && $past(link_en) |-> $stable(port_select); endproperty
  a_hold: assert property (p_hold) else $error("select moved");
endmodule

bind tlma_top tlma_checker #(.LW(LW)) tlma_checker_i (.*);

// file: testbench/tlma_partner.sv
`timescale 1ns/10ps
module tlma_partner #(
  parameter int LW = 10
) (
  // clock and bench controls
  input wire logic           clk_sys,
  input wire logic           plug,
  input wire logic           flip,
  input wire logic           chg,
  input wire logic [7:0]     lag,
  // cable pins
  output logic               vbus_sense = 1'b0,
  output logic               dp_line = 1'b0,
  output logic               dm_line = 1'b0,
  output logic               cc1_sense = 1'b0,
  output logic               cc2_sense = 1'b0,
  // lanes toward the design
  output logic [3:0][LW-1:0] lane_rx_data = '0
);
  int cnt = 0;
  int pat = 0;
  // lines settle lag cycles after vbus; lane words change every cycle
  always @(posedge clk_sys) begin
    cnt <= plug ? cnt + 1 : 0;
    pat <= pat + 1;
    vbus_sense <= plug;
    cc1_sense <= plug && !flip;
    cc2_sense <= plug && flip;
    dp_line <= plug && chg && cnt >= int'(lag);
    dm_line <= 1'b0;
    for (int i = 0; i < 4; i++) lane_rx_data[i] <= LW'(pat * 7 + i * 97);
  end
endmodule

// file: testbench/tb_typec_lane_mux_attach.sv
`timescale 1ns/10ps
module tb_typec_lane_mux_attach;
  import tlma_pkg::*;
  localparam int LW = 10;
  localparam logic [15:0] MAP [8] = '{16'hff54, 16'h54ff, 16'h0132,
    16'h3201, 16'h0154, 16'h5401, 16'hffff, 16'hffff};
  logic               clk_sys = 1'b0, nrst = 1'b0, link_en = 1'b0;
  logic [1:0]         phy_mode = 2'h3;
  logic               usb_tx_valid = 1'b0, psel_last = 1'b0;
  logic [LW-1:0]      usb_tx_data = '0, usb_rx_data;
  logic [3:0][LW-1:0] dp_ml_data = '0, lane_tx_data, lane_rx_data;
  logic               plug = 1'b0, flip = 1'b0, chg = 1'b0;
  logic [7:0]         lag = 8'h0;
  logic               vbus_sense, dp_line, dm_line, cc1_sense, cc2_sense;
  logic               cc_orientation_out_o, cc_orientation_out_oe;
  logic               attach_data, attach_charger, port_select;
  logic               secondary_hs_host, secondary_hs_pos_pd_en;
  logic               secondary_hs_neg_pd_en, usb_tx_ready, usb_rx_valid;
  logic               phy_port_select;
  logic [3:0]         lane_tx_en;
  int                 seed = 32'hc5b3, num_errors = 0, n_tests = 0;

  // undriven select pin shows the inverse of its last driven level
  assign phy_port_select = cc_orientation_out_oe ? cc_orientation_out_o
                                                 : !psel_last;
  always @(posedge clk_sys) begin
    if (cc_orientation_out_oe) psel_last <= cc_orientation_out_o;
  end

  tlma_top #(.LW(LW), .FIFO_DEPTH(TLMA_FIFO_DEPTH)) tlma_top_i (.*);
  tlma_partner #(.LW(LW)) tlma_partner_i (.*);

  initial begin
    forever #2 clk_sys = !clk_sys;
  end
  // the run needs about 1300 cycles; allow about fifteen times that
  initial begin
    #80000;
    num_errors++;
    complete_run();
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [3:0][LW-1:0] rnd();
    return (4 * LW)'({$random(seed), $random(seed)});
  endfunction

  task automatic attach(input logic f, input logic c);
    int n;
    @(posedge clk_sys);
    plug <= 1'b0;
    repeat (12) @(posedge clk_sys);
    flip <= f;
    chg <= c;
    lag <= 8'($random(seed) & 63);
    plug <= 1'b1;
    @(negedge clk_sys);
    chk("detached", 16'(attach_data | attach_charger), 16'h0);
    for (n = 0; n < 400 && !(attach_data || attach_charger); n++)
      @(negedge clk_sys);
    chk("settle", 16'(n >= TLMA_VBUS_SETTLE_CYC), 16'h1);
    chk("data", 16'(attach_data), 16'(!c));
    chk("charger", 16'(attach_charger), 16'(c));
    repeat (8) @(negedge clk_sys);
    chk("orient_oe", 16'(cc_orientation_out_oe), 16'h1);
    chk("orient", 16'(cc_orientation_out_o), 16'(f));
    chk("psel", 16'(port_select), 16'(f));
  endtask

  task automatic run_mode(input int m);
    logic [15:0]        t;
    logic [3:0][LW-1:0] p;
    logic [LW-1:0]      prx;
    int                 c, rl;
    t = MAP[m * 2 + int'(flip)];
    rl = -1;
    prx = '0;
    for (int l = 0; l < 4; l++) if (t[l*4+:4] == 4'h5) rl = l;
    @(posedge clk_sys);
    phy_mode <= 2'(m);
    link_en <= 1'b1;
    p = rnd();
    dp_ml_data <= p;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      dp_ml_data <= rnd();
      @(negedge clk_sys);
      for (int l = 0; l < 4; l++) begin
        c = t[l*4+:4];
        chk("lane_en", 16'(lane_tx_en[l]), 16'(c < 5));
        if (c < 4) chk("lane_ml", 16'(lane_tx_data[l]), 16'(p[c]));
        if (c == 4) chk("lane_tx", 16'(lane_tx_data[l]), 16'h0);
      end
      chk("rx_valid", 16'(usb_rx_valid), 16'(rl >= 0));
      if (i > 0 && rl >= 0) chk("rx_data", 16'(usb_rx_data), 16'(prx));
      if (rl >= 0) prx = lane_rx_data[rl];
      p = dp_ml_data;
    end
    @(posedge clk_sys);
    link_en <= 1'b0;
  endtask

  initial begin
    logic [LW-1:0] d, w, q[$];
    logic          rdy;
    int            tl;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(negedge clk_sys);
    d = 10'({secondary_hs_host, secondary_hs_pos_pd_en,
             secondary_hs_neg_pd_en});
    chk("hs_role", 16'(d), 16'h7);
    for (int s = 0; s < 2; s++) begin
      attach(s[0], 1'b0);
      for (int m = 0; m < 4; m++) run_mode(m);
    end
    attach(1'b1, 1'b1);
    attach(1'b0, 1'b0);
    // fill with the link down, then drain while the cable flips
    @(posedge clk_sys);
    phy_mode <= TLMA_MODE_USB3;
    d = LW'($random(seed) | 1);
    usb_tx_valid <= 1'b1;
    usb_tx_data <= d;
    rdy = 1'b1;
    for (int i = 0; i < 40 && rdy; i++) begin
      @(negedge clk_sys);
      rdy = usb_tx_ready;
      @(posedge clk_sys);
      if (rdy) begin
        q.push_back(d);
        d = LW'($random(seed) | 1);
        usb_tx_data <= d;
      end
    end
    usb_tx_valid <= 1'b0;
    chk("fill", 16'(q.size()), 16'(TLMA_FIFO_DEPTH));
    @(posedge clk_sys);
    link_en <= 1'b1;
    tl = flip ? TLMA_LANE_10 : TLMA_LANE_00;
    flip <= !flip;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      chk("psel_hold", 16'(port_select), 16'(!flip));
      if (lane_tx_data[tl] !== '0) begin
        w = (q.size() > 0) ? q.pop_front() : '0;
        chk("tx_word", 16'(lane_tx_data[tl]), 16'(w));
      end
    end
    chk("drained", 16'(q.size()), 16'h0);
    @(posedge clk_sys);
    link_en <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk("psel_free", 16'(port_select), 16'(flip));
    complete_run();
  end
endmodule
